/* hdl/pew_host.sv */
// Purpose : Host controller that reads and page-writes a parallel EEPROM
// Assumes : Pins sampled synchronously; one access in flight at a time
// Notes   : Writes end with poll-bit or toggle-line polling, bounded by a timeout
`timescale 1ns/1ps
module pew_host
   import pew_pkg::*;
#(
   parameter int TWC_LIMIT = TWC_CYC,
   parameter int BLC_LIMIT = BLC_CYC
) (
   input  wire logic              clk,          // 10 MHz clock
   input  wire logic              rstn,         // Synchronous reset, active low
   input  wire logic              req_valid,    // Request strobe
   input  wire logic              req_write,    // 1 write, 0 read
   input  wire logic              req_last,     // Last byte of a page load
   input  wire logic              req_locked,   // Precede write with lock sequence
   input  wire logic [ADDR_W-1:0] req_addr,     // Byte address
   input  wire logic [DATA_W-1:0] req_wdata,    // Write data
   output      logic              req_ready,    // Idle (any request) or page load open (write requests only), request may be taken
   output      logic              rsp_valid,    // Read data or write done pulse
   output      logic [DATA_W-1:0] rsp_rdata,    // Read data
   output      logic              rsp_timeout,  // Write poll ran out of time
   output      logic [ADDR_W-1:0] addr_lines,   // Address pins
   output      logic              chip_select_n,  // Chip select, active low
   output      logic              output_gate_n,  // Output gate, active low
   output      logic              write_strobe_n, // Write strobe, active low
   output      logic [DATA_W-1:0] data_out,     // Data lines, driven value
   output      logic              data_oe,      // Data lines, host drives when high
   input  wire logic [DATA_W-1:0] data_in       // Data lines, sampled value
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [6:0] {
      S_IDLE  = 7'b0000001,
      S_SETUP = 7'b0000010,
      S_WLOW  = 7'b0000100,
      S_WHIGH = 7'b0001000,
      S_LOAD  = 7'b0010000,
      S_RD    = 7'b0100000,
      S_POLL  = 7'b1000000
   } pew_state_type;

   typedef struct packed {
      pew_state_type     st;
      logic [1:0]        step;
      logic [1:0]        seq;
      logic              is_rd;
      logic              poll_rd;
      logic              have_prev;
      logic              last_hint;
      logic [7:0]        prev;
      logic [23:0]       cnt;
      logic [ADDR_W-1:0] pend_addr;
      logic [DATA_W-1:0] pend_data;
      logic              ready;
      logic              rv;
      logic [DATA_W-1:0] rdata;
      logic              tmo;
      logic [ADDR_W-1:0] a;
      logic              cs_n;
      logic              og_n;
      logic              ws_n;
      logic [DATA_W-1:0] d;
      logic              oe;
   } pew_regs_type;

   pew_regs_type s_reg;
   pew_regs_type s_next;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next     = s_reg;
      s_next.rv  = 1'b0;
      s_next.tmo = 1'b0;
      unique case (s_reg.st)
         S_IDLE: begin
            s_next.ready = 1'b1;
            if (req_valid && s_reg.ready) begin
               s_next.ready     = 1'b0;
               s_next.pend_addr = req_addr;
               s_next.pend_data = req_wdata;
               s_next.is_rd     = ~req_write;
               s_next.have_prev = 1'b0;
               if (req_write) begin
                  // Gate high before select and strobe go low
                  s_next.og_n = 1'b1; // RULE16
                  s_next.seq  = req_locked ? 2'd0 : 2'd3; // RULE21
                  s_next.st   = S_SETUP;
               end else begin
                  s_next.a    = req_addr;
                  s_next.ws_n = 1'b1;
                  s_next.cs_n = 1'b0; // RULE1
                  s_next.og_n = 1'b0;
                  s_next.oe   = 1'b0; // RULE2
                  s_next.step = 2'(STEP_CYC);
                  s_next.st   = S_RD;
               end
            end
         end
         S_SETUP: begin
            // Address and data stand still across the whole strobe pulse
            unique case (s_reg.seq)
               2'd0: begin
                  s_next.a = CMD_ADDR0;
                  s_next.d = CMD_DATA0;
               end
               2'd1: begin
                  s_next.a = CMD_ADDR1;
                  s_next.d = CMD_DATA1;
               end
               2'd2: begin
                  s_next.a = CMD_ADDR0;
                  s_next.d = CMD_LOCK_ON; // RULE20
               end
               2'd3: begin
                  s_next.a = s_reg.pend_addr; // RULE11 RULE12
                  s_next.d = s_reg.pend_data;
               end
            endcase
            s_next.oe   = 1'b1;
            s_next.cs_n = 1'b0;
            s_next.step = 2'(STEP_CYC);
            s_next.st   = S_WLOW;
         end
         S_WLOW: begin
            // Strobe low for at least the pulse width so no filter eats it
            s_next.ws_n = 1'b0; // RULE3 RULE4 RULE17
            if (s_reg.step == 2'd0) begin
               s_next.ws_n = 1'b1; // RULE5
               s_next.step = 2'(STEP_CYC);
               s_next.st   = S_WHIGH;
            end else if (!s_reg.ws_n) begin
               s_next.step = s_reg.step - 2'd1;
            end
         end
         S_WHIGH: begin
            if (s_reg.step != 2'd0) begin
               s_next.step = s_reg.step - 2'd1;
            end else begin
               s_next.cs_n = 1'b1;
               s_next.oe   = 1'b0;
               s_next.cnt  = '0;
               if (s_reg.seq != 2'd3) begin
                  // Command bytes use the same byte-load timing as data
                  s_next.seq = s_reg.seq + 2'd1; // RULE23
                  s_next.st  = S_SETUP;
               end else begin
                  // After a last byte stay not-ready, or a read would be taken and dropped
                  s_next.st    = S_LOAD;
                  s_next.ready = !s_reg.last_hint;
               end
            end
         end
         S_LOAD: begin
            // Further bytes must come well inside the load window
            s_next.cnt = s_reg.cnt + 24'd1; // RULE9
            if (req_valid && s_reg.ready && req_write && !s_reg.last_hint) begin
               s_next.ready     = 1'b0;
               s_next.pend_addr = {s_reg.pend_addr[ADDR_W-1:BYTE_W],
                                   req_addr[BYTE_W-1:0]}; // RULE11 RULE8
               s_next.pend_data = req_wdata;
               s_next.seq       = 2'd3;
               s_next.st        = S_SETUP;
            end else if (s_reg.last_hint || s_reg.cnt >= 24'(BLC_LIMIT / 2)) begin
               s_next.ready = 1'b0;
               s_next.cnt   = '0;
               s_next.st    = S_POLL; // RULE10 RULE25
            end
         end
         S_RD: begin
            if (s_reg.step != 2'd0) begin
               s_next.step = s_reg.step - 2'd1;
            end else begin
               s_next.cs_n = 1'b1;
               s_next.og_n = 1'b1;
               if (s_reg.is_rd) begin
                  s_next.rv    = 1'b1;
                  s_next.rdata = data_in;
                  s_next.st    = S_IDLE;
               end else begin
                  // Either sign ends the wait: a locked-out write never shows true data
                  if ((s_reg.have_prev &&
                       s_reg.prev[TOGGLE_BIT] == data_in[TOGGLE_BIT]) || // RULE15
                      data_in[POLL_BIT] == s_reg.pend_data[POLL_BIT]) begin // RULE14
                     s_next.rv = 1'b1;
                     s_next.st = S_IDLE;
                  end else begin
                     s_next.st = S_POLL;
                  end
                  s_next.have_prev = 1'b1;
                  s_next.prev      = data_in;
               end
            end
         end
         S_POLL: begin
            s_next.cnt = s_reg.cnt + 24'd1;
            if (s_reg.cnt >= 24'(TWC_LIMIT)) begin
               s_next.tmo = 1'b1; // RULE6
               s_next.rv  = 1'b1;
               s_next.st  = S_IDLE;
            end else if (s_reg.cs_n && s_reg.og_n) begin
               s_next.a    = s_reg.pend_addr; // RULE7
               s_next.cs_n = 1'b0;
               s_next.og_n = 1'b0;
               s_next.step = 2'(STEP_CYC);
               s_next.st   = S_RD;
            end
         end
         default: s_next.st = S_IDLE;
      endcase
      if (s_reg.st == S_IDLE || s_reg.st == S_LOAD) begin
         s_next.last_hint = req_valid && s_reg.ready && req_write && req_last;
      end
      if (s_reg.st == S_RD && s_reg.step == 2'd0 && !s_reg.is_rd &&
          s_next.st == S_POLL) begin
         s_next.cnt = s_reg.cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg      <= '0;
         s_reg.st   <= S_IDLE;
         s_reg.cs_n <= 1'b1;
         s_reg.og_n <= 1'b1;
         s_reg.ws_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign req_ready      = s_reg.ready;
   assign rsp_valid      = s_reg.rv;
   assign rsp_rdata      = s_reg.rdata;
   assign rsp_timeout    = s_reg.tmo;
   assign addr_lines     = s_reg.a;
   assign chip_select_n  = s_reg.cs_n;
   assign output_gate_n  = s_reg.og_n;
   assign write_strobe_n = s_reg.ws_n;
   assign data_out       = s_reg.d;
   assign data_oe        = s_reg.oe;

   ////////////////////////////////////////////////////////////////////////////////
   AST_GATE_HIGH_IN_WRITE: assert property (@(posedge clk) disable iff (!rstn) // RULE16
      !write_strobe_n |-> output_gate_n && !chip_select_n)
      else $error("write strobe low while deselected or with gate low");
   AST_NO_BUS_FIGHT: assert property (@(posedge clk) disable iff (!rstn) // RULE2
      !output_gate_n && !chip_select_n |-> !data_oe)
      else $error("host drives data lines during a read");
   AST_STROBE_WITH_DATA: assert property (@(posedge clk) disable iff (!rstn) // RULE3
      !write_strobe_n |-> data_oe)
      else $error("write strobe low without data driven");
   AST_ADDR_SETUP: assert property (@(posedge clk) disable iff (!rstn) // RULE4
      $fell(write_strobe_n) |-> $stable(addr_lines))
      else $error("address moved as the write strobe fell");
   AST_LATCH_STABLE: assert property (@(posedge clk) disable iff (!rstn) // RULE5
      !write_strobe_n |=> $stable(addr_lines) && $stable(data_out) && data_oe)
      else $error("address or data moved at the strobe rising edge");
   AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rstn) // RULE17
      $fell(write_strobe_n) |=> !write_strobe_n)
      else $error("write strobe pulse shorter than two cycles");
   AST_PAGE_FIXED: assert property (@(posedge clk) disable iff (!rstn) // RULE11
      s_reg.st == S_LOAD |=> $stable(s_reg.pend_addr[ADDR_W-1:BYTE_W]))
      else $error("page bits changed inside a page load");
   AST_LOAD_WINDOW: assert property (@(posedge clk) disable iff (!rstn) // RULE9
      s_reg.st == S_LOAD |-> s_reg.cnt < 24'(BLC_LIMIT))
      else $error("byte load window overrun");
   AST_POLL_BOUND: assert property (@(posedge clk) disable iff (!rstn) // RULE6
      s_reg.st == S_POLL |-> s_reg.cnt <= 24'(TWC_LIMIT))
      else $error("poll count beyond its limit");
endmodule : pew_host

/* hdl/pew_pkg.sv */
// Purpose : Constants for the paged EEPROM host-side write controller
// Assumes : 10 MHz clock, external part with 19 address lines, 8 data lines
// Notes   : Contract list below
//
// Contract
// RULE1 - Device drives data when selected and gated
// RULE2 - Device floats data if select or gate high
// RULE3 - Write starts on strobe low, gate high
// RULE4 - Address latched on later falling edge
// RULE5 - Data latched on first rising edge
// RULE6 - Device self-times programming, 10 ms max
// RULE7 - Reads during programming are status polls
// RULE8 - One to 256 bytes per page load
// RULE9 - Host writes next byte within 150 us
// RULE10 - Window expiry starts programming loaded bytes
// RULE11 - Host keeps page bits constant per load
// RULE12 - Byte bits pick byte; any order, rewrite
// RULE13 - Only loaded bytes get programmed
// RULE14 - Poll bit inverted until write completes
// RULE15 - Toggle line flips each read while busy
// RULE16 - No write with gate low or deselected
// RULE17 - Glitches under 15 ns ignored
// RULE18 - Writes blocked at low supply, 5 ms
// RULE19 - User turns write lock on and off; the host sends only the lock-on sequence
// RULE20 - Three-write sequence arms write lock
// RULE21 - Host sends unlock sequence before each write; the host sends it only for writes with req_locked set
// RULE22 - Write lock survives power cycling
// RULE23 - Command writes follow page-load timing
// RULE24 - Locked plain write only starts timer
// RULE25 - Host waits for poll completion before access; the host stops waiting after TWC_LIMIT poll rounds of three cycles each
package pew_pkg;
   localparam int          ADDR_W        = 19;
   localparam int          DATA_W        = 8;
   localparam int          BYTE_W        = 8;
   localparam int          CLK_NS        = 100;
   localparam int          WPULSE_NS     = 100;
   localparam int          STEP_CYC      = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int          BLC_US        = 150;
   localparam int          BLC_CYC       = (BLC_US * 1000) / CLK_NS;
   localparam int          TWC_MS        = 10;
   localparam int          TWC_CYC       = TWC_MS * 1000000 / CLK_NS;
   localparam int          POLL_BIT      = 7;
   localparam int          TOGGLE_BIT    = 6;
   localparam logic [18:0] CMD_ADDR0     = 19'h05555;
   localparam logic [18:0] CMD_ADDR1     = 19'h02aaa;
   localparam logic [7:0]  CMD_DATA0     = 8'haa;
   localparam logic [7:0]  CMD_DATA1     = 8'h55;
   localparam logic [7:0]  CMD_LOCK_ON   = 8'ha0;
   localparam logic [7:0]  CMD_LOCK_OFF  = 8'h20;
   localparam logic [7:0]  CMD_LOCK_OFF2 = 8'h80;
   localparam logic [7:0]  CMD_LOCK_OFF3 = 8'haa;
endpackage : pew_pkg

/* tb/pew_dev_model.sv */
// Purpose : Behavioural paged EEPROM facing the host controller
// Assumes : Times in ns; erased bytes read as ff
// Notes   : Lock-on sequence recognised; lock-off sequence not modelled
`timescale 1ns/1ps
module pew_dev_model
   import pew_pkg::*;
#(
   parameter int LOAD_NS = 8000,
   parameter int PROG_NS = 50000,
   parameter int PWRUP_NS = 500
) (
   input  wire logic [ADDR_W-1:0] addr_lines,     // Address pins
   input  wire logic              chip_select_n,  // Chip select
   input  wire logic              output_gate_n,  // Output gate
   input  wire logic              write_strobe_n, // Write strobe
   input  wire logic [DATA_W-1:0] bus,            // Resolved data lines
   output      logic [DATA_W-1:0] dout,           // Value driven when enabled
   output      logic              drive           // Model drives data lines
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] page [0:255];
   logic [255:0]      used = '0;
   logic [ADDR_W-1:0] lat_a;
   logic [DATA_W-1:0] last_d = 8'h00;
   logic              loading = 1'b0;
   logic              busy = 1'b0;
   logic              tog = 1'b0;
   realtime           t_last;
   realtime           t_fall = 0.0;
   logic [1:0]        cmd_seen = 2'd0;
   logic              cmd_ok = 1'b0;
   logic              lock_on = 1'b0;
   wire               wr_n = chip_select_n | write_strobe_n;
   wire               status = busy | loading;
   initial foreach (mem[i]) mem[i] = 8'hff;
   assign drive = !chip_select_n && !output_gate_n && write_strobe_n;
   // Any read after the first byte is a status poll until programming ends
   assign dout = status ? {~last_d[7], tog, last_d[5:0]} : mem[addr_lines];
   always @(negedge wr_n) begin
      lat_a  = addr_lines;
      t_fall = $realtime;
   end
   // Unknown pins before the host leaves reset must not open a load
   always @(posedge wr_n) begin
      if (output_gate_n === 1'b1 && !busy && !$isunknown(lat_a) &&
          $realtime - t_fall >= 15.0 && $realtime >= PWRUP_NS) begin
         if (cmd_seen == 2'd0 && lat_a == CMD_ADDR0 && bus == CMD_DATA0) begin
            cmd_seen = 2'd1;
         end else if (cmd_seen == 2'd1 && lat_a == CMD_ADDR1 && bus == CMD_DATA1) begin
            cmd_seen = 2'd2;
         end else if (cmd_seen == 2'd2 && lat_a == CMD_ADDR0 && bus == CMD_LOCK_ON) begin
            cmd_seen = 2'd0;
            cmd_ok   = 1'b1;
         end else begin
            cmd_seen = 2'd0;
            page[lat_a[7:0]] = bus;
            used[lat_a[7:0]] = 1'b1;
            last_d = bus;
         end
         loading = 1'b1;
         t_last = $realtime;
      end
   end
   always @(negedge (chip_select_n | output_gate_n)) if (status) tog = ~tog;
   always begin
      #100;
      if (loading && $realtime - t_last > LOAD_NS) begin
         loading = 1'b0;
         busy = 1'b1;
         #PROG_NS;
         // A locked part without the command sequence only runs its timer
         foreach (used[i]) begin
            if (used[i] && (!lock_on || cmd_ok)) begin
               mem[{lat_a[18:8], 8'(i)}] = page[i];
            end
         end
         lock_on  = lock_on | cmd_ok;
         cmd_ok   = 1'b0;
         cmd_seen = 2'd0;
         used = '0;
         busy = 1'b0;
      end
   end
endmodule : pew_dev_model

/* tb/pew_host_bench.sv */
// Purpose : Self-checking bench for the host-side EEPROM controller
// Assumes : One request at a time; write done reported after the last byte
// Notes   : Shortened write timeouts; lock-on sequence exercised last
`timescale 1ns/1ps
module pew_host_bench;
   import pew_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic req_last = 1'b0, req_locked = 1'b0, req_ready, rsp_valid, rsp_timeout;
   logic chip_select_n, output_gate_n, write_strobe_n, data_oe, drive;
   logic [ADDR_W-1:0] req_addr = '0, addr_lines;
   logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_out, dout, held = 8'h00;
   wire  [DATA_W-1:0] bus;
   logic [DATA_W-1:0] shadow [int];
   logic [8:0]        exp_q [$];
   logic [8:0]        e;
   logic [7:0]        seed = 8'h35;
   logic              lock_set = 1'b0;
   int                failures = 0, num_checks = 0;
   always #50 clk = ~clk;
   // Released lines show the inverse of their last level, never a stale value
   assign bus = data_oe ? data_out : (drive ? dout : ~held);
   always @(posedge clk) held <= bus;
   pew_host #(.TWC_LIMIT(2000), .BLC_LIMIT(50)) DUT (.clk(clk), .rstn(rstn),
      .req_valid(req_valid), .req_write(req_write), .req_last(req_last),
      .req_locked(req_locked), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_timeout(rsp_timeout), .addr_lines(addr_lines), .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
      .data_out(data_out), .data_oe(data_oe), .data_in(bus));
   pew_dev_model #(.LOAD_NS(8000), .PROG_NS(50000)) mdl (.addr_lines(addr_lines),
      .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
      .write_strobe_n(write_strobe_n), .bus(bus), .dout(dout), .drive(drive));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic stop_test();
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic check_data(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_data
   task automatic check_flag(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : check_flag
   task automatic send(logic w, logic l, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_last <= l;
      req_addr <= a;
      req_wdata <= d;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) begin
         failures++;
         stop_test();
      end
      @(posedge clk);
      req_valid <= 1'b0;
      if (!w) exp_q.push_back({1'b0, shadow.exists(a) ? shadow[a] : 8'hff});
      else begin
         if (!lock_set || req_locked) shadow[a] = d;
         if (req_locked) lock_set = 1'b1;
         if (l) exp_q.push_back(9'h100);
      end
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check_flag("unexpected response", 1'b0, 1'b1);
         else begin
            e = exp_q.pop_front();
            if (e[8]) check_flag("write timeout", 1'b0, rsp_timeout);
            else check_data("read data", e[7:0], rsp_rdata);
         end
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      send(1'b0, 1'b0, 19'h00123, 8'h00);
      // Reverse order, then byte 11 loaded again as the last byte
      for (int i = 3; i >= 0; i--) begin
         seed = lfsr(seed);
         send(1'b1, 1'b0, {11'h012, 8'(8'h10 + i)}, seed);
      end
      seed = lfsr(seed);
      send(1'b1, 1'b1, 19'h01211, seed);
      for (int i = 15; i < 21; i++) send(1'b0, 1'b0, {11'h012, 8'(i)}, 8'h00);
      // Full page: first byte plus 255 more
      for (int i = 0; i < 256; i++) begin
         seed = lfsr(seed);
         send(1'b1, i == 255, {11'h345, 8'(i)}, seed);
      end
      for (int i = 0; i < 256; i++) send(1'b0, 1'b0, {11'h345, 8'(i)}, 8'h00);
      send(1'b1, 1'b1, 19'h7ffff, 8'h5a);
      send(1'b0, 1'b0, 19'h7ffff, 8'h00);
      send(1'b0, 1'b0, 19'h7fffe, 8'h00);
      // Lock armed by a sequenced write; a plain write afterwards must not land
      req_locked <= 1'b1;
      send(1'b1, 1'b1, 19'h00abc, 8'h3c);
      req_locked <= 1'b0;
      send(1'b1, 1'b1, 19'h00abd, 8'h11);
      send(1'b0, 1'b0, 19'h00abc, 8'h00);
      send(1'b0, 1'b0, 19'h00abd, 8'h00);
      for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge clk);
      if (exp_q.size() != 0) failures++;
      stop_test();
   end
endmodule : pew_host_bench
